// ===== rtl/fpe_pkg.sv
// Constants, types and register map of the flash program/erase control
package fpe_pkg;
  // Register byte offsets (each register one aligned 32-bit word)
  localparam logic [7:0] FPE_CTRL_OFF = 8'h00;
  localparam logic [7:0] FPE_KEY_OFF = 8'h10;
  localparam logic [7:0] FPE_ADDR_OFF = 8'h20;
  localparam logic [7:0] FPE_DLO_OFF = 8'h30;
  localparam logic [7:0] FPE_DHI_OFF = 8'h40;
  // Alias word offsets from a register base, taken from address bits 3:2
  localparam logic [1:0] FPE_ALIAS_NONE = 2'h0;
  localparam logic [1:0] FPE_ALIAS_CLR = 2'h1;
  localparam logic [1:0] FPE_ALIAS_SET = 2'h2;
  localparam logic [1:0] FPE_ALIAS_INV = 2'h3;
  // Control register fields
  localparam int FPE_START_BIT = 15;
  localparam int FPE_ARM_BIT = 14;
  localparam int FPE_FAIL_BIT = 13;
  localparam int FPE_LV_BIT = 12;
  localparam int FPE_OPSEL_LSB = 0;
  localparam int FPE_OPSEL_W = 4;
  localparam logic [31:0] FPE_CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] FPE_WORD_RESET = 32'h0000_0000;
  // Unlock keys
  localparam logic [31:0] FPE_KEY_FIRST = 32'hAA99_6655;
  localparam logic [31:0] FPE_KEY_SECOND = 32'h5566_99AA;
  // Ignored low target address bits per operation
  localparam logic [31:0] FPE_PAGE_MASK = 32'hFFFF_F800;
  localparam logic [31:0] FPE_ROW_MASK = 32'hFFFF_FF00;
  localparam logic [31:0] FPE_DWORD_MASK = 32'hFFFF_FFFC;
  localparam logic [1:0] FPE_RESP_OKAY = 2'h0;
  localparam logic [1:0] FPE_RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    FPE_OP_NOP = 4'h0,
    FPE_OP_DWORD = 4'h2,
    FPE_OP_ROW = 4'h3,
    FPE_OP_PAGE = 4'h4,
    FPE_OP_CHIP = 4'h7
  } fpe_op_e;

  typedef enum logic [1:0] {
    FPE_K_IDLE = 2'b00,
    FPE_K_HALF = 2'b01,
    FPE_K_OPEN = 2'b11
  } fpe_key_e;

  typedef enum logic [1:0] {
    FPE_S_IDLE = 2'b00,
    FPE_S_LAUNCH = 2'b01,
    FPE_S_WAIT = 2'b11
  } fpe_seq_e;

  // Command handed to the flash array
  typedef struct packed {
    logic [3:0] op;
    logic [31:0] addr;
    logic [63:0] data;
  } fpe_cmd_s;
endpackage : fpe_pkg

// ===== rtl/fpe_top.sv
// Flash program/erase control registers and operation sequencer
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Software cannot clear start; setting needs arm set and fresh unlock.
// - Start launches selected operation; reads 1 while pending, 0 otherwise.
// - Arm 1 permits start writes, blocks op select; arm 0 the reverse.
// - Failure flag set on unsuccessful program or erase, else left 0; code also sets it on starting a reserved code.
// - Low-voltage flag set when supply too low during programming.
// - Both flags cleared only by starting operation code 0000.
// - Start, arm, flags, op select reset only by power-on reset.
// - Control bits 31-16 and 10-4 read 0; bit 11 kept 0.
// - Code 0111 erases all program flash, needs every page unprotected.
// - Code 0100 erases addressed page if unprotected.
// - Code 0011 programs addressed row if its page unprotected.
// - Code 0010 programs two words at address if page unprotected.
// - Unlock must precede each start write; otherwise write rejected.
// - Unlock key register is write-only and reads 0.
// - Target address register is full 32-bit read/write, resets 0.
// - Control has clear, set, invert aliases at plus 4, 8, 12.
// - Low address bits ignored: 10:0 page, 7:0 row, 1:0 dword.
// - Double-word data is high word over low word, low least significant.
module fpe_top
  import fpe_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic soft_rst_i,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Flash array side
  output logic flash_req_o,
  output fpe_cmd_s flash_cmd_o,
  input wire logic flash_done_i,
  input wire logic flash_fail_i,
  input wire logic low_voltage_i,
  input wire logic page_protected_i,
  input wire logic any_program_protected_i
);

  ////////////////////////////////////////////////////////////////////////////
  logic [1:0] por_sync_q;
  logic por_n;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      por_sync_q <= 2'b00;
    end else begin
      por_sync_q <= {por_sync_q[0], 1'b1};
    end
  end
  assign por_n = por_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  logic start_q, arm_q, fail_q, lv_q;
  logic [3:0] opsel_q;
  logic [31:0] addr_q, dlo_q, dhi_q;
  fpe_key_e key_q;
  fpe_seq_e seq_q;
  logic wr_fire, bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [7:0] wbase;
  logic [1:0] walias;
  logic [31:0] ctrl_rd, ctrl_new, wmask;
  logic wr_ctrl, start_set, op_end, op_nop, op_bad;

  function automatic logic [31:0] alias_apply(input logic [31:0] old,
      input logic [31:0] wd, input logic [31:0] m, input logic [1:0] al);
    logic [31:0] r;
    r = old;
    unique case (al)
      FPE_ALIAS_NONE: r = (old & ~m) | (wd & m);
      FPE_ALIAS_CLR: r = old & ~(wd & m);
      FPE_ALIAS_SET: r = old | (wd & m);
      FPE_ALIAS_INV: r = old ^ (wd & m);
    endcase
    return r;
  endfunction : alias_apply

  assign ctrl_rd = {16'h0000, start_q, arm_q, fail_q, lv_q, 8'h00,
                    opsel_q};

  ////////////////////////////////////////////////////////////////////////////
  // Write address and data taken together, one response outstanding
  assign wr_fire = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready = wr_fire;
  assign wbase = {s_axi_awaddr[7:4], 4'h0};
  assign walias = s_axi_awaddr[3:2];
  assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                  {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  assign wr_ctrl = wr_fire && wbase == FPE_CTRL_OFF;
  assign ctrl_new = alias_apply(ctrl_rd, s_axi_wdata, wmask, walias);
  // Only a 0->1 with arm already set and unlock just done counts
  assign start_set = wr_ctrl && ctrl_new[FPE_START_BIT] && !start_q
                     && arm_q && key_q == FPE_K_OPEN;

  always_ff @(posedge clk_i or negedge por_n) begin
    if (!por_n) begin
      bvalid_q <= 1'b0;
      bresp_q <= FPE_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= (wbase == FPE_CTRL_OFF || wbase == FPE_ADDR_OFF ||
                  s_axi_awaddr == FPE_DLO_OFF || s_axi_awaddr == FPE_DHI_OFF ||
                  s_axi_awaddr == FPE_KEY_OFF) ? FPE_RESP_OKAY
                                               : FPE_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  ////////////////////////////////////////////////////////////////////////////
  // Unlock: any write other than the expected key drops it
  always_ff @(posedge clk_i or negedge por_n) begin
    if (!por_n) begin
      key_q <= FPE_K_IDLE;
    end else if (soft_rst_i) begin
      key_q <= FPE_K_IDLE;
    end else if (wr_fire) begin
      if (s_axi_awaddr == FPE_KEY_OFF && s_axi_wdata == FPE_KEY_FIRST) begin
        key_q <= FPE_K_HALF;
      end else if (s_axi_awaddr == FPE_KEY_OFF && key_q == FPE_K_HALF &&
                   s_axi_wdata == FPE_KEY_SECOND) begin
        key_q <= FPE_K_OPEN;
      end else begin
        key_q <= FPE_K_IDLE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control bits: power-on reset only, soft reset ignored
  always_ff @(posedge clk_i or negedge por_n) begin
    if (!por_n) begin
      arm_q <= FPE_CTRL_RESET[FPE_ARM_BIT];
      opsel_q <= FPE_CTRL_RESET[FPE_OPSEL_W-1:0];
    end else if (wr_ctrl) begin
      arm_q <= ctrl_new[FPE_ARM_BIT];
      if (!arm_q) begin
        opsel_q <= ctrl_new[FPE_OPSEL_LSB +: FPE_OPSEL_W];
      end
    end
  end

  always_ff @(posedge clk_i or negedge por_n) begin
    if (!por_n) begin
      start_q <= FPE_CTRL_RESET[FPE_START_BIT];
    end else if (start_set) begin
      start_q <= 1'b1;
    end else if (op_end) begin
      start_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software-owned words: cleared by power-on or soft reset
  always_ff @(posedge clk_i or negedge por_n) begin
    if (!por_n) begin
      addr_q <= FPE_WORD_RESET;
      dlo_q <= FPE_WORD_RESET;
      dhi_q <= FPE_WORD_RESET;
    end else if (soft_rst_i) begin
      addr_q <= FPE_WORD_RESET;
      dlo_q <= FPE_WORD_RESET;
      dhi_q <= FPE_WORD_RESET;
    end else if (wr_fire) begin
      if (wbase == FPE_ADDR_OFF) begin
        addr_q <= alias_apply(addr_q, s_axi_wdata, wmask, walias);
      end
      if (s_axi_awaddr == FPE_DLO_OFF) begin
        dlo_q <= alias_apply(dlo_q, s_axi_wdata, wmask, FPE_ALIAS_NONE);
      end
      if (s_axi_awaddr == FPE_DHI_OFF) begin
        dhi_q <= alias_apply(dhi_q, s_axi_wdata, wmask, FPE_ALIAS_NONE);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  assign op_nop = opsel_q == FPE_OP_NOP;
  // Reserved codes and protected targets fail without touching the array
  always_comb begin
    unique case (opsel_q)
      FPE_OP_CHIP: op_bad = any_program_protected_i;
      FPE_OP_PAGE, FPE_OP_ROW, FPE_OP_DWORD:
        op_bad = page_protected_i;
      FPE_OP_NOP: op_bad = 1'b0;
      default: op_bad = 1'b1;
    endcase
  end
  assign op_end = (seq_q == FPE_S_LAUNCH && (op_nop || op_bad)) ||
                  (seq_q == FPE_S_WAIT && flash_done_i);

  always_ff @(posedge clk_i or negedge por_n) begin
    if (!por_n) begin
      seq_q <= FPE_S_IDLE;
    end else begin
      unique case (seq_q)
        FPE_S_IDLE: if (start_q) begin
          seq_q <= FPE_S_LAUNCH;
        end
        FPE_S_LAUNCH: seq_q <= (op_nop || op_bad) ? FPE_S_IDLE : FPE_S_WAIT;
        FPE_S_WAIT: if (flash_done_i) begin
          seq_q <= FPE_S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge por_n) begin
    if (!por_n) begin
      flash_req_o <= 1'b0;
      flash_cmd_o <= '0;
    end else begin
      flash_req_o <= seq_q == FPE_S_LAUNCH && !op_nop && !op_bad;
      if (seq_q == FPE_S_LAUNCH) begin
        flash_cmd_o.op <= opsel_q;
        flash_cmd_o.data <= {dhi_q, dlo_q};
        unique case (opsel_q)
          FPE_OP_PAGE: flash_cmd_o.addr <= addr_q & FPE_PAGE_MASK;
          FPE_OP_ROW: flash_cmd_o.addr <= addr_q & FPE_ROW_MASK;
          FPE_OP_DWORD: flash_cmd_o.addr <= addr_q & FPE_DWORD_MASK;
          default: flash_cmd_o.addr <= addr_q;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or negedge por_n) begin
    if (!por_n) begin
      fail_q <= FPE_CTRL_RESET[FPE_FAIL_BIT];
      lv_q <= FPE_CTRL_RESET[FPE_LV_BIT];
    end else if (seq_q == FPE_S_LAUNCH && op_nop) begin
      fail_q <= 1'b0;
      lv_q <= 1'b0;
    end else if (seq_q == FPE_S_LAUNCH && op_bad) begin
      fail_q <= 1'b1;
    end else if (seq_q == FPE_S_WAIT && flash_done_i) begin
      fail_q <= fail_q | flash_fail_i;
      lv_q <= lv_q | low_voltage_i;
    end else if (seq_q == FPE_S_WAIT && low_voltage_i) begin
      lv_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reads answer one cycle after acceptance
  assign s_axi_arready = !rvalid_q;

  always_ff @(posedge clk_i or negedge por_n) begin
    if (!por_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= FPE_RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rresp_q <= FPE_RESP_OKAY;
      unique case (s_axi_araddr)
        FPE_CTRL_OFF: rdata_q <= ctrl_rd;
        FPE_KEY_OFF: rdata_q <= 32'h0000_0000;
        FPE_ADDR_OFF: rdata_q <= addr_q;
        FPE_DLO_OFF: rdata_q <= dlo_q;
        FPE_DHI_OFF: rdata_q <= dhi_q;
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= FPE_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

endmodule : fpe_top

`default_nettype wire

// ===== verification/fpe_top_asserts.sv
// Checker of bus answers and flash commands
`timescale 1ns/1ps
`default_nettype none
module fpe_top_asserts
  import fpe_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic flash_req_o,
  input wire fpe_cmd_s flash_cmd_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////////////////
  wr_answer_a: assert property (s_axi_awvalid && s_axi_wvalid &&
    !s_axi_bvalid |=> s_axi_bvalid) else $error("no write answer");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  key_reads_zero_a: assert property (
    s_axi_arvalid && !s_axi_rvalid && s_axi_araddr == FPE_KEY_OFF
    |=> s_axi_rdata == 32'h0) else $error("key read not zero");
  ctrl_spare_zero_a: assert property (
    s_axi_arvalid && !s_axi_rvalid && s_axi_araddr == FPE_CTRL_OFF
    |=> s_axi_rdata[31:16] == 16'h0 && s_axi_rdata[11:4] == 8'h0)
    else $error("spare control bits set");
  req_pulse_a: assert property (flash_req_o |=> !flash_req_o)
    else $error("request longer than one cycle");
  legal_op_a: assert property (flash_req_o |-> flash_cmd_o.op inside
    {4'h2, 4'h3, 4'h4, 4'h7}) else $error("reserved op issued");
  page_mask_a: assert property (flash_req_o && flash_cmd_o.op == 4'h4
    |-> flash_cmd_o.addr[10:0] == 11'h0) else $error("page bits kept");
  row_mask_a: assert property (flash_req_o && flash_cmd_o.op == 4'h3
    |-> flash_cmd_o.addr[7:0] == 8'h0) else $error("row bits kept");
  dword_mask_a: assert property (flash_req_o && flash_cmd_o.op == 4'h2
    |-> flash_cmd_o.addr[1:0] == 2'h0) else $error("dword bits kept");
endmodule : fpe_top_asserts
`default_nettype wire

// ===== verification/testbench.sv
// Self-checking bench of the flash program/erase control
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fpe_pkg::*;
  logic clk_i = '0, rst_n_i = '0, soft_rst_i = '0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, d, a, lo, hi;
  logic [31:0] rnd = 32'h72F12BAF;
  logic [3:0] s_axi_wstrb = 4'hF, op, dly = '0;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0, flash_done_i = '0;
  logic flash_fail_i = '0, low_voltage_i = '0, page_protected_i = '0;
  logic any_program_protected_i = '0, fl = '0, lv = '0, go;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, flash_req_o;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [3:0] lg [4] = '{4'h2, 4'h3, 4'h4, 4'h7};
  fpe_cmd_s flash_cmd_o, cap;
  int n_errors = 0, n_compared = 0, n_req = 0, e_req = 0, cyc = 0;
  fpe_top fpe_top_i (.*);
  ////////////////////////////////////////////////////////////////////////////
  initial forever #5 clk_i = ~clk_i;
  // Sample on the falling edge so design flops have settled
  always @(negedge clk_i) begin
    dly <= {dly[2:0], flash_req_o};
    cyc <= cyc + 1;
    if (flash_req_o) begin
      cap <= flash_cmd_o;
      n_req <= n_req + 1;
    end
    if (cyc == 20000) begin
      n_errors++;
      complete_run();
    end
  end
  // Array answers four cycles after each request
  always @(posedge clk_i) flash_done_i <= dly[3];
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction : xs
  function automatic logic [31:0] ea(input logic [3:0] o, logic [31:0] v);
    case (o)
      4'h4: return v & FPE_PAGE_MASK;
      4'h3: return v & FPE_ROW_MASK;
      4'h2: return v & FPE_DWORD_MASK;
      default: return v;
    endcase
  endfunction : ea
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] ad, input logic [31:0] da);
    @(posedge clk_i);
    s_axi_awaddr <= ad;
    s_axi_wdata <= da;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(negedge clk_i); while (!(s_axi_awready && s_axi_wready));
    @(posedge clk_i);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(negedge clk_i); while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    @(posedge clk_i);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] ad);
    @(posedge clk_i);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge clk_i); while (!s_axi_arready);
    @(posedge clk_i);
    s_axi_arvalid <= 1'b0;
    do @(negedge clk_i); while (!s_axi_rvalid);
    d = s_axi_rdata;
    rsp = s_axi_rresp;
    @(posedge clk_i);
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic rc(input logic [7:0] ad, logic [31:0] ex, logic [1:0] er);
    rd(ad);
    check(d, ex);
    check({30'h0, rsp}, {30'h0, er});
  endtask : rc
  task automatic complete_run();
    $display("Counts: %0d compared, %0d mismatched", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rc(FPE_CTRL_OFF, FPE_CTRL_RESET, FPE_RESP_OKAY);
    rc(FPE_ADDR_OFF, FPE_WORD_RESET, FPE_RESP_OKAY);
    s_axi_wstrb <= 4'h3;
    wr(FPE_ADDR_OFF, 32'hFFFF_FFFF);
    s_axi_wstrb <= 4'hF;
    wr(FPE_ADDR_OFF + 8'h0C, 32'hFFFF_00F0);
    rc(FPE_ADDR_OFF, 32'hFFFF_FF0F, FPE_RESP_OKAY);
    wr(FPE_KEY_OFF, rnd);
    check({30'h0, rsp}, {30'h0, FPE_RESP_OKAY});
    rc(FPE_KEY_OFF, 32'h0, FPE_RESP_OKAY);
    wr(FPE_DLO_OFF + 8'h04, rnd);
    check({30'h0, rsp}, {30'h0, FPE_RESP_SLVERR});
    rc(FPE_DLO_OFF, FPE_WORD_RESET, FPE_RESP_OKAY);
    rc(8'h50, 32'h0, FPE_RESP_SLVERR);
    rc(FPE_CTRL_OFF + 8'h04, 32'h0, FPE_RESP_SLVERR);
    $display("reset and map test done");
    wr(FPE_CTRL_OFF, 32'h3);
    wr(FPE_CTRL_OFF, 32'h4003);
    wr(FPE_CTRL_OFF, 32'hC003);
    rc(FPE_CTRL_OFF, 32'h4003, FPE_RESP_OKAY);
    wr(FPE_CTRL_OFF, 32'hFFFF77F7);
    rc(FPE_CTRL_OFF, 32'h4003, FPE_RESP_OKAY);
    @(posedge clk_i) soft_rst_i <= 1'b1;
    @(posedge clk_i) soft_rst_i <= 1'b0;
    rc(FPE_CTRL_OFF, 32'h4003, FPE_RESP_OKAY);
    rc(FPE_ADDR_OFF, FPE_WORD_RESET, FPE_RESP_OKAY);
    $display("guard and soft reset test done");
    for (int i = 0; i < 28; i++) begin
      rnd = xs(rnd);
      op = (i < 16) ? i[3:0] : (rnd[5] ? 4'h0 : lg[rnd[4:3]]);
      go = op inside {4'h2, 4'h3, 4'h4, 4'h7} && !rnd[0];
      page_protected_i <= rnd[0];
      any_program_protected_i <= rnd[0];
      flash_fail_i <= rnd[1];
      low_voltage_i <= rnd[2] && go;
      a = xs(rnd);
      lo = xs(a);
      hi = xs(lo);
      wr(FPE_ADDR_OFF, a);
      wr(FPE_DLO_OFF, lo);
      wr(FPE_DHI_OFF, hi);
      wr(FPE_CTRL_OFF, 32'h0);
      wr(FPE_CTRL_OFF, {28'h0, op});
      wr(FPE_CTRL_OFF, {28'h0, op} | 32'h4000);
      wr(FPE_KEY_OFF, FPE_KEY_FIRST);
      wr(FPE_KEY_OFF, FPE_KEY_SECOND);
      if (rnd[6]) wr(FPE_CTRL_OFF + 8'h08, 32'h8000);
      else if (rnd[7]) wr(FPE_CTRL_OFF + 8'h0C, 32'h8000);
      else wr(FPE_CTRL_OFF, 32'hC000);
      // Clear attempt lands while the array is still busy
      if (go) begin
        wr(FPE_CTRL_OFF + 8'h04, 32'h8000);
        rd(FPE_CTRL_OFF);
        check({31'h0, d[15]}, 32'h1);
      end
      for (int k = 0; k < 40 && (k == 0 || d[15] !== 1'b0); k++)
        rd(FPE_CTRL_OFF);
      if (op == 4'h0) {fl, lv} = 2'b00;
      else if (go) {fl, lv} = {fl | rnd[1], lv | rnd[2]};
      else fl = 1'b1;
      e_req += go;
      check(d, {16'h0, 2'b01, fl, lv, 8'h0, op});
      check(n_req, e_req);
      if (go) begin
        check(cap.addr, ea(op, a));
        check({28'h0, cap.op}, {28'h0, op});
        check(cap.data[63:32], hi);
        check(cap.data[31:0], lo);
      end
    end
    $display("operation test done");
    complete_run();
  end
endmodule : testbench
bind fpe_top fpe_top_asserts fpe_top_asserts_i (.*);
`default_nettype wire
